/* File: src/imp_pkg.sv */
package imp_pkg;
   // Line numbers on the processor interrupt vector
   localparam int IRQ_LINES        = 21;
   localparam int LN_WAKE_LP       = 0;
   localparam int LN_RADIO_GEN     = 1;
   localparam int LN_UART_A        = 2;
   localparam int LN_UART_B        = 3;
   localparam int LN_I2C           = 4;
   localparam int LN_SPI           = 5;
   localparam int LN_ADC           = 6;
   localparam int LN_KEYPAD        = 7;
   localparam int LN_RADIO_DIAG    = 8;
   localparam int LN_RF_CAL        = 9;
   localparam int LN_PIN_BASE      = 10;
   localparam int PIN_LINES        = 5;
   localparam int LN_SOFT_TIMER    = 15;
   localparam int LN_WAKE_DECODER  = 16;
   localparam int LN_PCM           = 17;
   localparam int LN_RATE_IN       = 18;
   localparam int LN_RATE_OUT      = 19;
   localparam int LN_DMA           = 20;
   localparam int DIAG_EVENTS      = 8;

   // Register byte addresses
   localparam logic [11:0] A_STATUS     = 12'h000;
   localparam logic [11:0] A_MASK       = 12'h004;
   localparam logic [11:0] A_DIAG_SEL   = 12'h008;
   localparam logic [11:0] A_TICK_CTRL  = 12'h00C;
   localparam logic [11:0] A_TICK_LOAD  = 12'h010;
   localparam logic [11:0] A_TICK_VAL   = 12'h014;
   localparam logic [11:0] A_ACTIVE     = 12'h018;
   localparam logic [11:0] A_PENDING    = 12'h01C;
   localparam logic [11:0] A_PRIO_BASE  = 12'h100;

   // Tick control fields
   localparam int TC_ENABLE  = 0;
   localparam int TC_INTEN   = 1;
   localparam int TC_CLKSEL  = 2;
   localparam int TC_FLAG    = 16;
   localparam int TICK_W     = 24;
   localparam int PRIO_W     = 8;
   localparam int PRIO_KEEP  = 2;

   // Status bits of this block
   localparam int ST_TICK    = 0;
   localparam int ST_NMI     = 1;
   localparam int ST_BITS    = 2;

   localparam logic [7:0]  PRIO_RST = 8'h00;
   localparam logic [31:0] ZERO32   = 32'h0000_0000;
   localparam int LINE_ID_W = 5;

   // Radio general request sources
   typedef struct packed {
      logic event_end;
      logic cipher_done;
      logic soft_request;
      logic other;
   } imp_radio_t;

   // Arbiter result
   typedef struct packed {
      logic                 valid;
      logic [LINE_ID_W-1:0] line;
      logic [PRIO_KEEP-1:0] level;
   } imp_pick_t;
endpackage : imp_pkg

/* File: src/imp_top.sv */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Radio line merges event-end request
// - Radio line merges cipher-done request
// - Radio line merges software request
// - Line 8 carries selected diagnostic events
// - Lines 10-14 carry debounced pin requests
// - Line 16 ORs capture, pin, decoder
// - Lines 18, 19 carry rate converter requests
// - Smaller priority value wins
// - Byte priority fields reset to zero
// - Equal priority: lowest line wins
// - Watchdog alarm drives non-maskable input
// - Select 0: tick on 1 MHz enable
// - Select 1: tick on processor clock
// - Tick select resets to reference
// - Only four priority levels compared
// - 24-bit tick counter, own exception
module imp_top
   import imp_pkg::*;
#(
   parameter int NLINES = IRQ_LINES
) (
   input  wire logic                  CLK,
   input  wire logic                  SRST,
   input  wire logic                  CE,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [11:0]           PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire imp_radio_t            RADIO_GEN,
   input  wire logic                  RADIO_WAKE,
   input  wire logic [DIAG_EVENTS-1:0] RADIO_DIAG_EVT,
   input  wire logic                  UART_A,
   input  wire logic                  UART_B,
   input  wire logic                  I2C,
   input  wire logic                  SPI,
   input  wire logic                  ADC,
   input  wire logic                  KEYPAD,
   input  wire logic                  RF_CAL,
   input  wire logic [PIN_LINES-1:0]  PIN_DEBOUNCED,
   input  wire logic                  SOFT_TIMER,
   input  wire logic                  WAKE_CAPTURE,
   input  wire logic                  WAKE_PIN,
   input  wire logic                  DECODER,
   input  wire logic                  PCM,
   input  wire logic                  RATE_IN,
   input  wire logic                  RATE_OUT,
   input  wire logic                  DMA,
   input  wire logic                  WATCHDOG_ALARM,
   input  wire logic                  TICK_REFERENCE_ENABLE,
   output logic      [NLINES-1:0]     IRQ_LINE,
   output imp_pick_t                  IRQ_PICK,
   output logic                       NMI,
   output logic                       TICK_EXCEPTION,
   output logic                       IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [NLINES-1:0]      irq_line_r;
   logic [NLINES-1:0]      lines_nxt;
   logic [PRIO_W-1:0]      prio_r [NLINES];
   logic [DIAG_EVENTS-1:0] radio_diag_select_r;
   logic                   tick_en_r;
   logic                   tick_inten_r;
   logic                   tick_clock_select_r;
   logic                   tick_flag_r;
   logic [TICK_W-1:0]      tick_load_r;
   logic [TICK_W-1:0]      tick_val_r;
   logic [ST_BITS-1:0]     status_r;
   logic [ST_BITS-1:0]     mask_r;
   imp_pick_t              pick_r;
   imp_pick_t              pick_nxt;
   logic                   nmi_r;
   logic                   tick_exc_r;
   logic                   irq_r;
   logic [31:0]            prdata_r;
   logic                   pready_r;
   logic                   pslverr_r;
   logic                   tick_step;
   logic                   tick_wrap;
   logic                   wr_en;
   logic                   rd_en;
   logic                   addr_ok;
   logic [31:0]            rd_nxt;

   // Decode helper shared by read mux and write logic
   function automatic logic prio_hit(input logic [11:0] a, output int idx);
      idx = int'((a - A_PRIO_BASE) >> 2);
      return (a >= A_PRIO_BASE) && (idx < NLINES) && (a[1:0] == 2'b00);
   endfunction : prio_hit

   ////////////////////////////////////////////////////////////////////////////
   // Source mapping onto numbered lines
   always_comb begin
      lines_nxt = '0;
      lines_nxt[LN_WAKE_LP] = RADIO_WAKE;
      lines_nxt[LN_RADIO_GEN] = RADIO_GEN.event_end
                              | RADIO_GEN.cipher_done
                              | RADIO_GEN.soft_request
                              | RADIO_GEN.other;
      lines_nxt[LN_UART_A] = UART_A;
      lines_nxt[LN_UART_B] = UART_B;
      lines_nxt[LN_I2C] = I2C;
      lines_nxt[LN_SPI] = SPI;
      lines_nxt[LN_ADC] = ADC;
      lines_nxt[LN_KEYPAD] = KEYPAD;
      lines_nxt[LN_RADIO_DIAG] = |(RADIO_DIAG_EVT & radio_diag_select_r);
      lines_nxt[LN_RF_CAL] = RF_CAL;
      for (int i = 0; i < PIN_LINES; i++) begin
         lines_nxt[LN_PIN_BASE + i] = PIN_DEBOUNCED[i];
      end
      lines_nxt[LN_SOFT_TIMER] = SOFT_TIMER;
      lines_nxt[LN_WAKE_DECODER] = WAKE_CAPTURE | WAKE_PIN | DECODER;
      lines_nxt[LN_PCM] = PCM;
      lines_nxt[LN_RATE_IN] = RATE_IN;
      lines_nxt[LN_RATE_OUT] = RATE_OUT;
      lines_nxt[LN_DMA] = DMA;
   end

   // Registered so the core sees glitch-free levels
   always_ff @(posedge CLK) begin
      if (SRST) begin
         irq_line_r <= '0;
      end else if (CE) begin
         irq_line_r <= lines_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority resolution over registered lines
   always_comb begin
      pick_nxt = '0;
      // Strict less-than keeps the lowest line on a tie
      for (int i = 0; i < NLINES; i++) begin
         if (irq_line_r[i] &&
             (!pick_nxt.valid ||
              prio_r[i][PRIO_W-1 -: PRIO_KEEP] < pick_nxt.level)) begin
            pick_nxt.valid = 1'b1;
            pick_nxt.line  = LINE_ID_W'(i);
            pick_nxt.level = prio_r[i][PRIO_W-1 -: PRIO_KEEP];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pick_r <= '0;
      end else if (CE) begin
         pick_r <= pick_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog goes to the non-maskable input and, through status bit ST_NMI, to IRQ
   always_ff @(posedge CLK) begin
      if (SRST) begin
         nmi_r <= 1'b0;
      end else if (CE) begin
         nmi_r <= WATCHDOG_ALARM;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tick counter; divided clock is the CE-qualified CLK itself
   assign tick_step = tick_en_r && (tick_clock_select_r ? 1'b1 : TICK_REFERENCE_ENABLE);
   assign tick_wrap = tick_step && (tick_val_r == '0);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_val_r <= '0;
      end else if (CE) begin
         if (wr_en && PADDR == A_TICK_VAL) begin
            tick_val_r <= '0;
         end else if (tick_wrap) begin
            tick_val_r <= tick_load_r;
         end else if (tick_step) begin
            tick_val_r <= tick_val_r - 1'b1;
         end
      end
   end

   // Flag clears on control read; a wrap in that cycle wins
   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_flag_r <= 1'b0;
      end else if (CE) begin
         if (tick_wrap) begin
            tick_flag_r <= 1'b1;
         end else if (rd_en && PADDR == A_TICK_CTRL) begin
            tick_flag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_exc_r <= 1'b0;
      end else if (CE) begin
         tick_exc_r <= tick_wrap && tick_inten_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave; access phase with one wait state
   assign wr_en   = PSEL && PENABLE && PWRITE && !pready_r;
   assign rd_en   = PSEL && PENABLE && !PWRITE && !pready_r;

   always_comb begin
      int k;
      k = 0;
      addr_ok = 1'b1;
      rd_nxt  = ZERO32;
      case (PADDR)
         A_STATUS:    rd_nxt = 32'(status_r);
         A_MASK:      rd_nxt = 32'(mask_r);
         A_DIAG_SEL:  rd_nxt = 32'(radio_diag_select_r);
         A_TICK_CTRL: begin
            rd_nxt[TC_ENABLE] = tick_en_r;
            rd_nxt[TC_INTEN]  = tick_inten_r;
            rd_nxt[TC_CLKSEL] = tick_clock_select_r;
            rd_nxt[TC_FLAG]   = tick_flag_r;
         end
         A_TICK_LOAD: rd_nxt = 32'(tick_load_r);
         A_TICK_VAL:  rd_nxt = 32'(tick_val_r);
         A_ACTIVE:    rd_nxt = 32'(irq_line_r);
         A_PENDING:   rd_nxt = 32'(pick_r);
         default: begin
            if (prio_hit(PADDR, k)) begin
               rd_nxt = 32'(prio_r[k]);
            end else begin
               addr_ok = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pready_r  <= 1'b0;
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (CE) begin
         pready_r  <= PSEL && PENABLE && !pready_r;
         pslverr_r <= PSEL && PENABLE && !pready_r && !addr_ok;
         if (rd_en) begin
            prdata_r <= rd_nxt;
         end
      end
   end

   // Control register writes
   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_en_r           <= 1'b0;
         tick_inten_r        <= 1'b0;
         tick_clock_select_r <= 1'b0;
         tick_load_r         <= '0;
         radio_diag_select_r <= '0;
         mask_r              <= '0;
      end else if (CE && wr_en) begin
         case (PADDR)
            A_TICK_CTRL: begin
               tick_en_r           <= PWDATA[TC_ENABLE];
               tick_inten_r        <= PWDATA[TC_INTEN];
               tick_clock_select_r <= PWDATA[TC_CLKSEL];
            end
            A_TICK_LOAD: tick_load_r <= PWDATA[TICK_W-1:0];
            A_DIAG_SEL:  radio_diag_select_r <= PWDATA[DIAG_EVENTS-1:0];
            A_MASK:      mask_r <= PWDATA[ST_BITS-1:0];
            default: ;
         endcase
      end
   end

   // Priority bytes, writable per line
   always_ff @(posedge CLK) begin
      int k;
      k = 0;
      if (SRST) begin
         for (int i = 0; i < NLINES; i++) begin
            prio_r[i] <= PRIO_RST;
         end
      end else if (CE && wr_en && prio_hit(PADDR, k)) begin
         prio_r[k] <= PWDATA[PRIO_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event wins
   always_ff @(posedge CLK) begin
      logic [ST_BITS-1:0] ev;
      ev = '0;
      ev[ST_TICK] = tick_wrap;
      ev[ST_NMI]  = WATCHDOG_ALARM && !nmi_r;
      if (SRST) begin
         status_r <= '0;
      end else if (CE) begin
         if (wr_en && PADDR == A_STATUS) begin
            status_r <= (status_r & ~PWDATA[ST_BITS-1:0]) | ev;
         end else begin
            status_r <= status_r | ev;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         irq_r <= 1'b0;
      end else if (CE) begin
         irq_r <= |(status_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign IRQ_LINE       = irq_line_r;
   assign IRQ_PICK       = pick_r;
   assign NMI            = nmi_r;
   assign TICK_EXCEPTION = tick_exc_r;
   assign IRQ            = irq_r;
   assign PRDATA         = prdata_r;
   assign PREADY         = pready_r;
   assign PSLVERR        = pslverr_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   gpio_map_a: assert property (@(posedge CLK) disable iff (SRST)
      CE |=> IRQ_LINE[LN_PIN_BASE] == $past(PIN_DEBOUNCED[0]))
      else $error("pin line 0 mismatch");
   radio_merge_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && RADIO_GEN.cipher_done |=> IRQ_LINE[LN_RADIO_GEN])
      else $error("radio cipher request lost");
   radio_event_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && RADIO_GEN.event_end |=> IRQ_LINE[LN_RADIO_GEN])
      else $error("radio event request lost");
   radio_soft_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && RADIO_GEN.soft_request |=> IRQ_LINE[LN_RADIO_GEN])
      else $error("radio soft request lost");
   wake_comb_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && DECODER |=> IRQ_LINE[LN_WAKE_DECODER])
      else $error("decoder request lost");
   rate_out_a: assert property (@(posedge CLK) disable iff (SRST)
      CE |=> IRQ_LINE[LN_RATE_OUT] == $past(RATE_OUT))
      else $error("rate output line mismatch");
   nmi_route_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && WATCHDOG_ALARM |=> NMI)
      else $error("watchdog not on nmi");
   pick_tie_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && irq_line_r[0] && irq_line_r[1] && prio_r[0] == prio_r[1] |=> IRQ_PICK.line != LINE_ID_W'(1))
      else $error("tie not won by lowest line");
   tick_ref_a: assert property (@(posedge CLK) disable iff (SRST)
      CE && tick_en_r && !tick_clock_select_r && !TICK_REFERENCE_ENABLE && !wr_en |=> $stable(tick_val_r))
      else $error("tick moved without reference enable");

   tick_wrap_c: cover property (@(posedge CLK) disable iff (SRST) tick_wrap);
   pick_valid_c: cover property (@(posedge CLK) disable iff (SRST) pick_r.valid && pick_r.line == LINE_ID_W'(LN_DMA));
   irq_out_c: cover property (@(posedge CLK) disable iff (SRST) $rose(irq_r));
endmodule : imp_top

/* File: verif/imp_core_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Core side of the vector input: counts tick and non-maskable entries
module imp_core_model
   import imp_pkg::*;
(
   input  wire logic      CLK,
   input  wire logic      SRST,
   input  wire imp_pick_t IRQ_PICK,
   input  wire logic      NMI,
   input  wire logic      TICK_EXCEPTION,
   output int             tick_taken,
   output int             nmi_taken
);
   logic nmi_q;
   logic [4:0] taken_line;

   // A held alarm is one entry, so only its rise counts
   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_taken <= 0;
         nmi_taken  <= 0;
         nmi_q      <= 1'b0;
         taken_line <= 5'h00;
      end else begin
         nmi_q <= NMI;
         if (NMI && !nmi_q) nmi_taken <= nmi_taken + 1;
         if (TICK_EXCEPTION) tick_taken <= tick_taken + 1;
         if (IRQ_PICK.valid) taken_line <= IRQ_PICK.line;
      end
   end
endmodule : imp_core_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
////////////////////////////////////////////////////////////////////////////////
module testbench;
   import imp_pkg::*;
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, perr;
   logic        alarm, tick_ref, ref_on, nmi, tick_exc, irq, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv, held;
   logic [32:0] src;
   logic [20:0] lines, exp_l;
   logic [7:0]  prio [0:20];
   logic [7:0]  dsel;
   imp_pick_t   pick, exp_p;
   int          err_total, checked, seed, cyc, ref_cnt, t0, nn, tick_taken, nmi_taken;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   imp_top dut (.CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RADIO_GEN(imp_radio_t'(src[3:0])), .RADIO_WAKE(src[4]), .RADIO_DIAG_EVT(src[12:5]),
      .UART_A(src[13]), .UART_B(src[14]), .I2C(src[15]), .SPI(src[16]), .ADC(src[17]),
      .KEYPAD(src[18]), .RF_CAL(src[19]), .PIN_DEBOUNCED(src[24:20]), .SOFT_TIMER(src[25]),
      .WAKE_CAPTURE(src[26]), .WAKE_PIN(src[27]), .DECODER(src[28]), .PCM(src[29]),
      .RATE_IN(src[30]), .RATE_OUT(src[31]), .DMA(src[32]), .WATCHDOG_ALARM(alarm),
      .TICK_REFERENCE_ENABLE(tick_ref), .IRQ_LINE(lines), .IRQ_PICK(pick), .NMI(nmi),
      .TICK_EXCEPTION(tick_exc), .IRQ(irq));

   imp_core_model core (.CLK(clk), .SRST(srst), .IRQ_PICK(pick), .NMI(nmi), .TICK_EXCEPTION(tick_exc),
      .tick_taken(tick_taken), .nmi_taken(nmi_taken));

   // 1 MHz reference enable: one pulse every 250 cycles
   always @(posedge clk) begin
      ref_cnt <= (ref_cnt == 249) ? 0 : ref_cnt + 1;
      tick_ref <= ref_on && (ref_cnt == 249);
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end

   // Expected line vector from the source bundle
   function automatic logic [20:0] map_lines(logic [32:0] s, logic [7:0] d);
      logic [20:0] e;
      e = {s[32:29], |s[28:26], s[25], s[24:20], s[19], |(s[12:5] & d), s[18:13], |s[3:0], s[4]};
      return e;
   endfunction : map_lines

   // Top two priority bits only; strict compare keeps the lowest line on ties
   function automatic imp_pick_t arb(logic [20:0] l);
      imp_pick_t p;
      int        best;
      p = '0;
      best = 4;
      for (int i = 0; i < 21; i++) begin
         if (l[i] && (int'(prio[i][7:6]) < best)) begin
            best = int'(prio[i][7:6]);
            p = {1'b1, 5'(i), 2'(best)};
         end
      end
      return p;
   endfunction : arb

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits for PREADY; only the hang guard ends a wait that never sees it
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic chk_map();
      repeat (3) @(posedge clk);
      exp_l = map_lines(src, dsel);
      exp_p = arb(exp_l);
      `CHK(lines, exp_l)
      if (exp_p.valid) `CHK(pick, exp_p)
      else `CHK(pick.valid, 1'b0)
   endtask : chk_map

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   initial begin
      {psel, penable, pwrite, paddr, pwdata, src, alarm, ref_on, tick_ref, ref_cnt, cyc} = '0;
      {err_total, checked, dsel} = '0;
      seed = 32'h8394_578b;
      ce = 1'b1;
      srst = 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, A_TICK_CTRL, ZERO32);
      `CHK(rdv[2:0], 3'b000)
      // Random priorities, diagnostic select and sources
      for (int it = 0; it < 24; it++) begin
         for (int i = 0; i < 21; i++) begin
            if (it == 0) apb(1'b0, A_PRIO_BASE + 12'(4 * i), ZERO32);
            if (it == 0) `CHK(rdv[7:0], PRIO_RST)
            prio[i] = 8'($random(seed));
            apb(1'b1, A_PRIO_BASE + 12'(4 * i), {24'h00_0000, prio[i]});
            if (it == 0) apb(1'b0, A_PRIO_BASE + 12'(4 * i), ZERO32);
            if (it == 0) `CHK(rdv[7:0], prio[i])
         end
         dsel = 8'($random(seed));
         apb(1'b1, A_DIAG_SEL, {24'h00_0000, dsel});
         src <= {1'($random(seed)), 32'($random(seed))};
         chk_map();
      end
      // Walking one: every source alone reaches the line it maps to
      dsel = 8'hFF;
      apb(1'b1, A_DIAG_SEL, 32'h0000_00FF);
      for (int b = 0; b < 33; b++) begin
         src <= 33'h1 << b;
         chk_map();
      end
      // Clock enable low freezes lines and pick
      ce <= 1'b0;
      src <= '0;
      repeat (3) @(posedge clk);
      `CHK(lines, exp_l)
      `CHK(pick, exp_p)
      ce <= 1'b1;
      // Unmapped places are refused
      apb(1'b0, 12'h020, ZERO32);
      `CHK({perr, rdv}, {1'b1, ZERO32})
      apb(1'b1, 12'h024, 32'h0000_0005);
      `CHK(perr, 1'b1)
      apb(1'b1, A_TICK_LOAD, 32'hFFFF_FFFF);
      apb(1'b0, A_TICK_LOAD, ZERO32);
      `CHK(rdv, 32'h00FF_FFFF)
      // Processor clock: reload 5 wraps every 6 cycles
      apb(1'b1, A_TICK_LOAD, 32'h0000_0005);
      apb(1'b1, A_TICK_VAL, ZERO32);
      t0 = tick_taken;
      apb(1'b1, A_TICK_CTRL, 32'h0000_0007);
      repeat (60) @(posedge clk);
      `CHK((tick_taken - t0 >= 9) && (tick_taken - t0 <= 11), 1'b1)
      // Reference clock: no step without the enable, 6 pulses give 3 wraps
      apb(1'b1, A_TICK_LOAD, 32'h0000_0001);
      apb(1'b1, A_TICK_CTRL, 32'h0000_0003);
      // Start from zero, or a high leftover value eats the wraps
      apb(1'b1, A_TICK_VAL, ZERO32);
      // Wrap flag set by the earlier run, cleared by a control read
      apb(1'b0, A_TICK_CTRL, ZERO32);
      `CHK(rdv[16], 1'b1)
      apb(1'b0, A_TICK_CTRL, ZERO32);
      `CHK({rdv[16], rdv[2:0]}, 4'b0011)
      apb(1'b0, A_TICK_VAL, ZERO32);
      held = rdv;
      repeat (20) @(posedge clk);
      apb(1'b0, A_TICK_VAL, ZERO32);
      `CHK(rdv, held)
      t0 = tick_taken;
      ref_on <= 1'b1;
      repeat (1500) @(posedge clk);
      `CHK((tick_taken - t0 >= 2) && (tick_taken - t0 <= 4), 1'b1)
      ref_on <= 1'b0;
      apb(1'b1, A_TICK_CTRL, ZERO32);
      // Sticky wrap bit, masked level output, write-one clear
      apb(1'b1, A_MASK, 32'h0000_0001);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(1'b1, A_STATUS, 32'h0000_0001);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      // Watchdog alarm reaches the non-maskable input and the masked status bit, not the lines
      nn = nmi_taken;
      alarm <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(nmi, 1'b1)
      `CHK(lines, 21'h00_0000)
      `CHK(irq, 1'b0)
      apb(1'b1, A_MASK, 32'h0000_0002);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      alarm <= 1'b0;
      apb(1'b1, A_STATUS, 32'h0000_0002);
      repeat (3) @(posedge clk);
      `CHK({nmi, irq}, 2'b00)
      `CHK(nmi_taken - nn, 1)
      finish_test();
   end
endmodule : testbench
